// *** hdl/hcd_delineation.sv ***
`timescale 1ns/1ns
// Function
// - Exactly three states: hunt, presync, sync.
// - Start in hunt after reset.
// - Hunt: check byte over four octets vs fifth.
// - Hunt mismatch: slip one bit, retry.
// - Hunt match moves to presync.
// - Presync: check a header every 53 bytes.
// - Presync: one mismatch returns to hunt.
// - Presync: DELTA matches in a row enter sync.
// - Sync entry clears loss flag and state field.
// - Sync entry raises regained interrupt, pin low.
// - Control byte 2: bits 1,0 writable, rest zero.
// - Processing runs only while enable bit is set.
// - Sync: ALPHA bad headers return to hunt.

// Small byte FIFO between the upstream stream and the delineator.
module hcd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input  wire logic             mclk,
    input  wire logic             rstn,
    // Filling side.
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Draining side.
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];   // Storage words.
    logic [AW-1:0]    wr_ff, nxt_wr;    // Write pointer.
    logic [AW-1:0]    rd_ff, nxt_rd;    // Read pointer.
    logic [AW:0]      cnt_ff, nxt_cnt;  // Words held.
    logic             rdy_ff, nxt_rdy;  // Registered room indication.
    logic             push, pop;

    // Pointer and fill level arithmetic; ready is registered so it never depends on the drain in the same cycle.
    always_comb begin
        push    = in_valid && rdy_ff;
        pop     = out_ready && (cnt_ff != '0);
        nxt_wr  = push ? AW'(wr_ff + 1'b1) : wr_ff;
        nxt_rd  = pop ? AW'(rd_ff + 1'b1) : rd_ff;
        nxt_cnt = (AW+1)'(cnt_ff + (AW+1)'(push) - (AW+1)'(pop));
        nxt_rdy = (nxt_cnt != (AW+1)'(DEPTH));
    end

    // Register the pointers; storage carries no reset.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
            rdy_ff <= 1'b0;
        end else begin
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            cnt_ff <= nxt_cnt;
            rdy_ff <= nxt_rdy;
        end
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    assign in_ready  = rdy_ff;
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ff];
endmodule

// Cell delineation with its control, status and interrupt registers.
module hcd_delineation (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rstn,
    // Unframed byte stream from the path overhead logic.
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_valid,
    output logic             rx_ready,
    // Microprocessor register port.
    input  wire logic [11:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // Events.
    output logic             int_n,
    output logic             cell_start
);
    // Header check byte over a 32-bit header, MSB first.
    function automatic logic [7:0] hec_calc(input logic [31:0] hdr);
        logic [7:0] crc;
        crc = 8'h00;
        for (int i = 31; i >= 0; i--) begin
            crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ hdr[i]) ? hcd_pkg::HEC_POLY : 8'h00);
        end
        return crc ^ hcd_pkg::HEC_COSET;
    endfunction

    hcd_pkg::hcd_state_t state_ff, nxt_state;  // Delineation state.
    logic [47:0] win_ff, nxt_win;              // Last six bytes, oldest first.
    logic [5:0]  pos_ff, nxt_pos;              // Bytes since last check.
    logic [2:0]  off_ff, nxt_off;              // Bit offset of the candidate.
    logic [3:0]  good_ff, nxt_good;            // Consecutive matches in presync.
    logic [3:0]  bad_ff, nxt_bad;              // Consecutive errors in sync.
    logic        loss_ff, nxt_loss;            // Alignment loss flag.
    logic [1:0]  ctrl_ff, nxt_ctrl;            // Control byte 2 bits.
    logic [1:0]  int_ff, nxt_int;              // Interrupt status bits.
    logic        intn_ff, nxt_intn;            // Interrupt pin.
    logic [7:0]  rdata_ff, nxt_rdata;          // Read data.
    logic        start_ff, nxt_start;          // Cell boundary pulse.
    logic [7:0]  fifo_byte;
    logic        fifo_valid;
    logic        pop, check, match, en;
    logic [47:0] win_now;
    logic [39:0] cand;
    logic [1:0]  field;
    logic        int_set_decl, int_set_clr;

    // Buffer between the stream and the search; the search stalls it while disabled.
    hcd_fifo #(.WIDTH(hcd_pkg::DATA_W), .DEPTH(hcd_pkg::FIFO_DEPTH)) u_fifo (
        .mclk      (mclk),
        .rstn      (rstn),
        .in_data   (rx_byte),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .out_data  (fifo_byte),
        .out_valid (fifo_valid),
        .out_ready (en)
    );

    // Candidate extraction and header check; a larger offset takes later bits.
    always_comb begin
        en      = ctrl_ff[hcd_pkg::CTRL_EN_BIT];
        pop     = fifo_valid && en;
        win_now = {win_ff[39:0], fifo_byte};
        cand    = win_now[47 - off_ff -: 40];
        check   = pop && (pos_ff == hcd_pkg::CELL_LAST);
        match   = (hec_calc(cand[39:8]) == cand[7:0]);
    end

    // Search state machine, byte counter and loss flag.
    always_comb begin
        nxt_state    = state_ff;
        nxt_win      = pop ? win_now : win_ff;
        nxt_pos      = pop ? ((pos_ff == hcd_pkg::CELL_LAST) ? 6'h00 : 6'(pos_ff + 1'b1)) : pos_ff;
        nxt_off      = off_ff;
        nxt_good     = good_ff;
        nxt_bad      = bad_ff;
        nxt_loss     = loss_ff;
        nxt_start    = 1'b0;
        int_set_decl = 1'b0;
        int_set_clr  = 1'b0;
        if (check) begin
            unique case (state_ff)
                hcd_pkg::ST_HUNT: begin
                    if (match) begin
                        nxt_state = hcd_pkg::ST_PRESYNC;
                        nxt_good  = 4'h0;
                    end else begin
                        // Slip one bit; past bit 7 the next byte is used, one byte later.
                        nxt_off = 3'(off_ff + 1'b1);
                        if (off_ff == 3'h7) begin
                            nxt_pos = hcd_pkg::POS_EXTRA;
                        end
                    end
                end
                hcd_pkg::ST_PRESYNC: begin
                    if (!match) begin
                        nxt_state = hcd_pkg::ST_HUNT;
                    end else if (good_ff == hcd_pkg::DELTA_LAST) begin
                        nxt_state   = hcd_pkg::ST_SYNC;
                        nxt_loss    = 1'b0;
                        nxt_bad     = 4'h0;
                        int_set_clr = 1'b1;
                    end else begin
                        nxt_good = 4'(good_ff + 1'b1);
                    end
                end
                hcd_pkg::ST_SYNC: begin
                    if (match) begin
                        nxt_bad   = 4'h0;
                        nxt_start = 1'b1;
                    end else if (bad_ff == hcd_pkg::ALPHA_LAST) begin
                        nxt_state    = hcd_pkg::ST_HUNT;
                        nxt_loss     = 1'b1;
                        int_set_decl = 1'b1;
                    end else begin
                        nxt_bad = 4'(bad_ff + 1'b1);
                    end
                end
            endcase
        end
    end

    // Search registers; reset places the machine in hunt with alignment lost.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_ff <= hcd_pkg::ST_HUNT;
            win_ff   <= 48'h0;
            pos_ff   <= 6'h00;
            off_ff   <= 3'h0;
            good_ff  <= 4'h0;
            bad_ff   <= 4'h0;
            loss_ff  <= 1'b1;
            start_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            win_ff   <= nxt_win;
            pos_ff   <= nxt_pos;
            off_ff   <= nxt_off;
            good_ff  <= nxt_good;
            bad_ff   <= nxt_bad;
            loss_ff  <= nxt_loss;
            start_ff <= nxt_start;
        end
    end

    // Register port: writes, clear-on-read interrupt bits and read data.
    always_comb begin
        unique case (state_ff)
            hcd_pkg::ST_HUNT:    field = hcd_pkg::FLD_HUNT;
            hcd_pkg::ST_PRESYNC: field = hcd_pkg::FLD_PRESYNC;
            hcd_pkg::ST_SYNC:    field = hcd_pkg::FLD_SYNC;
            default:             field = hcd_pkg::FLD_HUNT;
        endcase
        nxt_ctrl = ctrl_ff;
        if (reg_wr && reg_addr == hcd_pkg::CTRL2_ADDR) begin
            nxt_ctrl = reg_wdata[1:0];
        end
        // A read clears the byte, but an event in the same cycle still lands.
        nxt_int = int_ff;
        if (reg_rd && reg_addr == hcd_pkg::INTSTAT_ADDR) begin
            nxt_int = 2'h0;
        end
        nxt_int[hcd_pkg::INT_DECL_BIT] = nxt_int[hcd_pkg::INT_DECL_BIT] | int_set_decl;
        nxt_int[hcd_pkg::INT_CLR_BIT]  = nxt_int[hcd_pkg::INT_CLR_BIT] | int_set_clr;
        nxt_intn = ~|nxt_int;
        nxt_rdata = rdata_ff;
        if (reg_rd) begin
            unique case (reg_addr)
                hcd_pkg::CTRL2_ADDR:   nxt_rdata = {6'h00, ctrl_ff};
                hcd_pkg::STATUS_ADDR:  nxt_rdata = {5'h00, field, loss_ff};
                hcd_pkg::INTSTAT_ADDR: nxt_rdata = {6'h00, int_ff};
                default:               nxt_rdata = 8'h00;
            endcase
        end
    end

    // Register-port flops.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ctrl_ff  <= hcd_pkg::CTRL_RESET;
            int_ff   <= 2'h0;
            intn_ff  <= 1'b1;
            rdata_ff <= 8'h00;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            int_ff   <= nxt_int;
            intn_ff  <= nxt_intn;
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata  = rdata_ff;
    assign int_n      = intn_ff;
    assign cell_start = start_ff;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence enter_sync_s;
        state_ff == hcd_pkg::ST_PRESYNC ##1 state_ff == hcd_pkg::ST_SYNC;
    endsequence
    sequence sync_fail_s;
        state_ff == hcd_pkg::ST_SYNC && check && !match && bad_ff == hcd_pkg::ALPHA_LAST;
    endsequence

    state_onehot_a: assert property ($onehot(state_ff))
        else $error("state is not one-hot");
    reset_hunt_a: assert property (@(posedge mclk) disable iff (1'b0)
        !rstn |=> state_ff == hcd_pkg::ST_HUNT && loss_ff)
        else $error("reset did not leave hunt");
    hunt_slip_a: assert property (
        state_ff == hcd_pkg::ST_HUNT && check && !match |=> off_ff == 3'($past(off_ff) + 1'b1))
        else $error("hunt mismatch did not slip one bit");
    hunt_match_a: assert property (
        state_ff == hcd_pkg::ST_HUNT && check && match |=> state_ff == hcd_pkg::ST_PRESYNC)
        else $error("hunt match did not enter presync");
    presync_fail_a: assert property (
        state_ff == hcd_pkg::ST_PRESYNC && check && !match |=> state_ff == hcd_pkg::ST_HUNT)
        else $error("presync mismatch did not return to hunt");
    presync_count_a: assert property (
        enter_sync_s |-> $past(good_ff) == hcd_pkg::DELTA_LAST && $past(match))
        else $error("sync entered without full confirmation");
    sync_status_a: assert property (enter_sync_s |-> !loss_ff)
        else $error("loss flag not cleared on sync entry");
    regain_int_a: assert property (
        enter_sync_s |-> int_ff[hcd_pkg::INT_CLR_BIT] && !int_n)
        else $error("regained interrupt missing");
    ctrl_read_a: assert property (
        reg_rd && reg_addr == hcd_pkg::CTRL2_ADDR |=> reg_rdata[7:2] == 6'h00)
        else $error("unused control bits not zero");
    disabled_hold_a: assert property (!en |=> $stable(state_ff) && $stable(pos_ff))
        else $error("search moved while disabled");
    sync_loss_a: assert property (
        sync_fail_s |=> state_ff == hcd_pkg::ST_HUNT && loss_ff && int_ff[hcd_pkg::INT_DECL_BIT])
        else $error("loss of alignment not declared");
endmodule

// *** hdl/hcd_pkg.sv ***
// Shared constants and types for the receive cell delineation block.
package hcd_pkg;

    // Register offsets on the 8-bit microprocessor port.
    localparam logic [11:0] CTRL2_ADDR   = 12'h701;
    localparam logic [11:0] STATUS_ADDR  = 12'h707;
    localparam logic [11:0] INTSTAT_ADDR = 12'h70b;

    // Control byte 2 layout and value after reset.
    localparam int          CTRL_EN_BIT  = 1;
    localparam logic [1:0]  CTRL_RESET   = 2'h2;

    // Status register layout; the state field sits in bits 2 and 1.
    localparam int          STAT_LOSS_BIT  = 0;
    localparam int          STAT_FIELD_LSB = 1;
    localparam logic [1:0]  FLD_HUNT       = 2'h3;
    localparam logic [1:0]  FLD_PRESYNC    = 2'h1;
    localparam logic [1:0]  FLD_SYNC       = 2'h0;

    // Interrupt status byte 0 layout.
    localparam int          INT_DECL_BIT = 0;
    localparam int          INT_CLR_BIT  = 1;

    // Cell geometry and the header check code.
    localparam logic [5:0]  CELL_LAST  = 6'h34;
    localparam logic [5:0]  POS_EXTRA  = 6'h3f;
    localparam logic [7:0]  HEC_POLY   = 8'h07;
    localparam logic [7:0]  HEC_COSET  = 8'h55;

    // Confirmation and loss thresholds, expressed as the last count value.
    localparam logic [3:0]  DELTA_LAST = 4'h5;
    localparam logic [3:0]  ALPHA_LAST = 4'h6;

    // Input buffer shape.
    localparam int          DATA_W     = 8;
    localparam int          FIFO_DEPTH = 4;

    // Delineation states, one-hot.
    typedef enum logic [2:0] {
        ST_HUNT    = 3'h1,
        ST_PRESYNC = 3'h2,
        ST_SYNC    = 3'h4
    } hcd_state_t;

endpackage

// *** verification/hcd_src_model.sv ***
`timescale 1ns/1ns
// Upstream byte source: endless cells, shifted by SHIFT bits off the byte grid.
module hcd_src_model #(
    parameter int SHIFT = 3
) (
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       rstn,
    // Commands from the bench.
    input  wire logic       run,
    input  wire logic       slow,
    input  wire logic       bad,
    // Byte stream.
    output logic      [7:0] rx_byte,
    output logic            rx_valid,
    input  wire logic       rx_ready
);
    localparam logic [31:0] HDR = 32'h0012_3450;
    logic [5:0]  idx;  // Next byte position in the cell.
    logic [7:0]  prv;  // Previous cell byte.
    logic [7:0]  cur;  // Current cell byte.
    logic        ph;   // Offer phase in slow mode.
    logic [15:0] two;  // Two bytes to cut the shifted byte from.
    // Header check byte over four octets.
    function automatic logic [7:0] hec(input logic [31:0] h);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 31; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
        end
        return c ^ 8'h55;
    endfunction
    // Byte i of a cell; a zero payload can never pass for a header.
    function automatic logic [7:0] cb(input logic [5:0] i, input logic b);
        if (i < 6'h04) return HDR[31 - 8 * i -: 8];
        if (i == 6'h04) return hec(HDR) ^ {7'h00, b};
        return 8'h00;
    endfunction
    assign two      = {prv, cur} >> SHIFT;
    assign rx_valid = run && (!slow || ph);
    // An idle line shows the inverse, so stale data is never mistaken for fresh.
    assign rx_byte  = rx_valid ? two[7:0] : ~two[7:0];
    // Advance only on an accepted byte; an offer is held until it is taken.
    always @(posedge mclk) begin
        if (!rstn) begin
            idx <= 6'h01;
            prv <= 8'h00;
            cur <= cb(6'h00, 1'b0);
            ph  <= 1'b0;
        end else begin
            if (!(rx_valid && !rx_ready)) ph <= ~ph;
            if (rx_valid && rx_ready) begin
                prv <= cur;
                cur <= cb(idx, bad);
                idx <= (idx == 6'h34) ? 6'h00 : idx + 6'h01;
            end
        end
    end
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/1ns
// Self-checking bench for the cell delineation block.
module testbench;
    logic        mclk;
    logic        rstn;
    logic [7:0]  rx_byte;
    logic        rx_valid;
    logic        rx_ready;
    logic [11:0] reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        int_n;
    logic        cell_start;
    logic        run;   // Source offers bytes.
    logic        slow;  // Source offers every other cycle.
    logic        bad;   // Source corrupts header check bytes.
    int          fails;
    int          comparisons;

    hcd_delineation dut (.mclk(mclk), .rstn(rstn), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .int_n(int_n), .cell_start(cell_start));
    hcd_src_model src (.mclk(mclk), .rstn(rstn), .run(run), .slow(slow),
        .bad(bad), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready));

    // A 40 ns clock.
    always #20 mclk = ~mclk;

    // Count and report a comparison.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Print the counts and the verdict, then end the run.
    task automatic tally_and_finish;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // A bound that ran out ends the run.
    task automatic to_end(input int n, input int lim);
        if (n >= lim) begin
            fails++;
            $display("unexpected timeout at %0t: got %h want below %h", $time, n, lim);
            tally_and_finish();
        end
    endtask
    // One register cycle; the read byte is taken once it has settled.
    task automatic acc(input logic [11:0] a, input logic w, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wr    <= w;
        reg_rd    <= !w;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge mclk);
        q = reg_rdata;
    endtask
    // Read one register and compare it.
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        logic [7:0] q;
        acc(a, 1'b0, 8'h00, q);
        chk(q, e);
    endtask
    // Write one register; the read-back byte is not used.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(a, 1'b1, d, q);
    endtask
    // Wait for the interrupt line to fall.
    task automatic wait_int(input int lim);
        int n;
        n = 0;
        while (int_n !== 1'b0 && n < lim) begin
            @(posedge mclk);
            n++;
        end
        to_end(n, lim);
    endtask
    // Poll the status until the search confirms a candidate.
    task automatic wait_presync;
        logic [7:0] q;
        int n;
        q = 8'h07;
        n = 0;
        while (q !== 8'h03 && n < 12000) begin
            acc(12'h707, 1'b0, 8'h00, q);
            n++;
        end
        to_end(n, 12000);
    endtask
    // Cycles between two good-header pulses.
    task automatic gap(input logic [7:0] e);
        int n;
        n = 0;
        while (cell_start !== 1'b1 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        to_end(n, 400);
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (cell_start !== 1'b1 && n < 400);
        chk(n[7:0], e);
    endtask
    // Values straight after reset; an unmapped offset reads zero.
    task automatic after_reset;
        chk({7'h00, int_n}, 8'h01);
        rd(12'h701, 8'h02);
        rd(12'h707, 8'h07);
        rd(12'h70b, 8'h00);
        rd(12'h123, 8'h00);
    endtask
    // Disabled: the buffer fills and refuses, the search stays put.
    task automatic hold_off;
        wr(12'h701, 8'hff);
        rd(12'h701, 8'h03);
        wr(12'h701, 8'h00);
        run <= 1'b1;
        repeat (8) @(posedge mclk);
        chk({7'h00, rx_ready}, 8'h00);
        rd(12'h707, 8'h07);
        wr(12'h701, 8'h02);
    endtask
    // Still in presync after five confirmations, so a sixth is needed before sync.
    task automatic acquire;
        wait_presync();
        repeat (280) @(posedge mclk);
        rd(12'h707, 8'h03);
        wait_int(300);
        rd(12'h707, 8'h00);
        rd(12'h70b, 8'h02);
        chk({7'h00, int_n}, 8'h01);
    endtask
    // Six bad headers leave sync standing; the seventh declares the loss.
    task automatic lose;
        int n;
        n = 0;
        while (cell_start !== 1'b1 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        to_end(n, 400);
        bad <= 1'b1;
        repeat (340) @(posedge mclk);
        rd(12'h707, 8'h00);
        wait_int(1000);
        rd(12'h707, 8'h07);
        rd(12'h70b, 8'h01);
    endtask
    // One bad header during confirmation drops back to the search.
    task automatic presync_miss;
        bad <= 1'b0;
        wait_presync();
        bad <= 1'b1;
        // Read back before a second check could land, so one miss alone must do it.
        repeat (60) @(posedge mclk);
        rd(12'h707, 8'h07);
    endtask

    initial begin
        mclk = 1'b0;
        rstn = 1'b0;
        reg_addr = 12'h000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        run = 1'b0;
        slow = 1'b0;
        bad = 1'b0;
        fails = 0;
        comparisons = 0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        after_reset();
        hold_off();
        acquire();
        gap(8'h35);
        slow <= 1'b1;
        repeat (60) @(posedge mclk);
        gap(8'h6a);
        slow <= 1'b0;
        lose();
        presync_miss();
        tally_and_finish();
    end
endmodule
